// file: verif/special_ctrl_regs_checker.sv
// Assertion checker for the special control register bank
`timescale 1ns/1ps
`include "ctrl_regs_defs.vh"

module special_ctrl_regs_checker (
    // Clock, reset and strobes
    input wire       ref_clk,
    input wire       srst,
    input wire       write_prescale_reg_instr,
    input wire       control_space_read_instr,
    input wire       control_space_write_instr,
    input wire       disable_interrupts_instr,
    input wire       enable_interrupts_instr,
    input wire       return_from_interrupt_instr,
    input wire [3:0] ctrl_addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_data,
    // Events
    input wire       usb_suspend,
    input wire       wake_signal,
    input wire       set_feature_wake,
    // Decoded controls
    input wire [2:0] watchdog_prescale_sel,
    input wire [7:0] watchdog_ratio,
    input wire [8:0] timer_ratio,
    input wire       int_blocked,
    input wire [7:0] port5_dir,
    input wire       spi_edge_select,
    input wire       spi_enable_bit,
    input wire       spi_master,
    input wire [6:0] spi_divisor,
    input wire [1:0] port9_pullup_en,
    input wire       remote_wake_supported,
    input wire       system_clock_run,
    input wire       resume_request
);
    // Write data one cycle back; $past on a slice is not portable
    reg [7:0] wd_q;
    always @(posedge ref_clk) begin
        wd_q <= wr_data;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence spi_wr_s;
        control_space_write_instr && ctrl_addr == `IDX_SPI_CTRL;
    endsequence
    sequence wake_fall_s;
        $fell(wake_signal);
    endsequence
    sequence susp_fall_s;
        $fell(usb_suspend);
    endsequence
    reset_vals_a: assert property ($fell(srst) |-> port5_dir == 8'hFF
        && watchdog_prescale_sel == 3'h7 && !int_blocked)
        else $error("bad values after reset");
    wdt_ratio_a: assert property (
        watchdog_ratio == (8'h01 << watchdog_prescale_sel))
        else $error("watchdog ratio wrong");
    prescale_wr_a: assert property (write_prescale_reg_instr |=>
        timer_ratio == (9'h002 << wd_q[5:3]))
        else $error("timer ratio not written");
    idis_kept_a: assert property (write_prescale_reg_instr
        && !disable_interrupts_instr && !enable_interrupts_instr
        && !return_from_interrupt_instr |=> $stable(int_blocked))
        else $error("disable bit moved by write");
    int_off_a: assert property (disable_interrupts_instr |=>
        int_blocked)
        else $error("interrupts not blocked");
    int_on_a: assert property ((enable_interrupts_instr
        || return_from_interrupt_instr) && !disable_interrupts_instr
        |=> !int_blocked)
        else $error("interrupts not permitted");
    spi_edge_a: assert property (spi_wr_s |=>
        spi_edge_select == wd_q[7] && spi_enable_bit == wd_q[6])
        else $error("spi edge or enable wrong");
    spi_rate_a: assert property (spi_wr_s
        ##0 wr_data[2:1] != 2'h3 |=>
        spi_master && spi_divisor == (7'h02 << wd_q[2:0]))
        else $error("spi divisor wrong");
    p9_pullup_a: assert property (control_space_read_instr
        && ctrl_addr == `IDX_P9_PULLUP |-> port9_pullup_en == ~rd_data[3:2])
        else $error("port 9 pull-up decode wrong");
    unmapped_rd_a: assert property (control_space_read_instr
        && ctrl_addr < 4'h5 |-> rd_data == 8'h00)
        else $error("unmapped index read not zero");
    wake_run_a: assert property (wake_fall_s |->
        ##[2:5] system_clock_run)
        else $error("run bit not set by wake");
    resume_clr_a: assert property (susp_fall_s |->
        ##[2:5] !resume_request)
        else $error("resume request not cleared");
    remote_set_a: assert property ($rose(set_feature_wake) |->
        ##[2:5] remote_wake_supported)
        else $error("remote wake not set");
endmodule // special_ctrl_regs_checker

bind special_ctrl_regs special_ctrl_regs_checker chk_i (.*);

// file: verif/special_ctrl_regs_tb.sv
// Self-checking testbench for the special control register bank
`timescale 1ns/1ps
`include "ctrl_regs_defs.vh"

module special_ctrl_regs_tb;
    reg ref_clk, srst, read_prescale_reg_instr, write_prescale_reg_instr;
    reg control_space_read_instr, control_space_write_instr;
    reg disable_interrupts_instr, enable_interrupts_instr;
    reg return_from_interrupt_instr, acc_load, int_taken, acc_restore;
    reg set_feature_wake, clear_feature_wake, usb_suspend, wake_signal;
    reg [3:0] ctrl_addr;
    reg [7:0] wr_data, acc_d;
    wire [7:0] rd_data, acc_value, acc_saved, watchdog_ratio;
    wire [7:0] port5_dir, port6_dir, port7_dir, port9_dir;
    wire [8:0] timer_ratio;
    wire [6:0] spi_divisor;
    wire [2:0] watchdog_prescale_sel, timer_prescale_sel, port9_wake_en;
    wire [1:0] port9_led_sink, port9_pullup_en, op_mode, dual_freq_sel;
    wire int_blocked, watchdog_enable_bit, port7_led_sink, port7_pullup_en;
    wire port5_pullup_en, port6_pullup_en, port_change_wake_disable;
    wire spi_enable_bit, spi_edge_select, sck_idle_level, sdo_open_drain;
    wire sck_open_drain, spi_master, spi_ss_honored, remote_wake_supported;
    wire normal_clock, usb_ctrl_run, system_clock_run, resume_request;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;

    special_ctrl_regs special_ctrl_regs_i (.*);

    always #2.5 ref_clk = ~ref_clk;
    // Ceiling well above the roughly 170 cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            wrap_up;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task csw(input [3:0] a, input [7:0] d);
        @(posedge ref_clk);
        control_space_write_instr <= 1'b1;
        ctrl_addr <= a;
        wr_data <= d;
        @(posedge ref_clk);
        control_space_write_instr <= 1'b0;
        #1;
    endtask
    task csr(input [3:0] a, input [7:0] exp);
        @(posedge ref_clk);
        control_space_read_instr <= 1'b1;
        ctrl_addr <= a;
        #1;
        chk("rd_data", rd_data, exp);
        @(posedge ref_clk);
        control_space_read_instr <= 1'b0;
    endtask
    task rpr(input [7:0] exp);
        @(posedge ref_clk);
        read_prescale_reg_instr <= 1'b1;
        #1;
        chk("prescale", rd_data, exp);
        @(posedge ref_clk);
        read_prescale_reg_instr <= 1'b0;
    endtask
    task wpr(input [7:0] d);
        @(posedge ref_clk);
        write_prescale_reg_instr <= 1'b1;
        wr_data <= d;
        @(posedge ref_clk);
        write_prescale_reg_instr <= 1'b0;
        #1;
    endtask
    // Bits: 0 disable, 1 enable, 2 return
    task instr(input [2:0] m, input exp);
        @(posedge ref_clk);
        disable_interrupts_instr <= m[0];
        enable_interrupts_instr <= m[1];
        return_from_interrupt_instr <= m[2];
        @(posedge ref_clk);
        {disable_interrupts_instr, enable_interrupts_instr} <= 2'b00;
        return_from_interrupt_instr <= 1'b0;
        #1;
        chk("int_blocked", int_blocked, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rpr(`RST_PRESCALE);
        for (int i = 0; i < 16; i++) begin
            csr(i, (i == 8) ? `RST_SPI_CTRL : (i >= 5 && i <= 9) ? 8'hFF :
                (i == 10) ? `RST_MODE_CTRL : (i == 11) ? `RST_P9_WAKE :
                (i == 12) ? `RST_P9_LED : (i == 13) ? `RST_P9_PULLUP :
                (i == 14) ? `RST_SPECIAL : 8'h00);
        end
        $display("test reset done");
    endtask
    task t_prescale;
        for (int c = 0; c < 8; c++) begin
            wpr({2'b11, c[2:0], c[2:0]});
            chk("wdt", watchdog_ratio, 9'h001 << c);
            chk("tmr", timer_ratio, 9'h002 << c);
            chk("tsel", timer_prescale_sel, c);
            chk("wsel", watchdog_prescale_sel, c);
            chk("led", port7_led_sink, 9'h001);
            rpr({2'b10, c[2:0], c[2:0]});
        end
        wpr(8'h00);
        chk("led", port7_led_sink, 9'h000);
        $display("test prescale done");
    endtask
    task t_int;
        instr(3'b001, 1'b1);
        rpr(8'h40);
        instr(3'b010, 1'b0);
        instr(3'b001, 1'b1);
        instr(3'b100, 1'b0);
        instr(3'b011, 1'b1);
        instr(3'b010, 1'b0);
        $display("test interrupts done");
    endtask
    task t_spi;
        csw(`IDX_SPI_CTRL, 8'hC0);
        chk("edge", {spi_edge_select, spi_enable_bit}, 9'h003);
        chk("idle", sck_idle_level, 9'h001);
        csw(`IDX_SPI_CTRL, 8'h30);
        chk("idle", sck_idle_level, 9'h000);
        chk("od", {sdo_open_drain, sck_open_drain}, 9'h003);
        csw(`IDX_SPI_CTRL, 8'hFF);
        csr(`IDX_SPI_CTRL, 8'hF7);
        for (int c = 0; c < 8; c++) begin
            csw(`IDX_SPI_CTRL, c);
            chk("master", spi_master, c < 6);
            if (c < 6) chk("div", spi_divisor, 9'h002 << c);
            else chk("ss", spi_ss_honored, c == 6);
        end
        $display("test spi done");
    endtask
    task t_mode;
        for (int m = 0; m < 4; m++) begin
            csw(`IDX_MODE_CTRL, {m[1:0], 4'h0, m[1:0]});
            chk("mode", op_mode, m);
            chk("freq", dual_freq_sel, m);
            chk("p7pu", port7_pullup_en, m == 1);
        end
        csw(`IDX_MODE_CTRL, 8'h21);
        chk("p7pu", port7_pullup_en, 9'h000);
        $display("test mode done");
    endtask
    task t_ports;
        csw(`IDX_P9_WAKE, 8'h00);
        csw(`IDX_P9_LED, 8'hFF);
        csw(`IDX_P9_PULLUP, 8'h00);
        csw(`IDX_PORT6_DIR, 8'h0F);
        chk("p6dir", port6_dir, 9'h00F);
        chk("dirs", port5_dir & port7_dir & port9_dir, 9'h0FF);
        chk("wake", port9_wake_en, 9'h007);
        chk("p9led", port9_led_sink, 9'h003);
        chk("p9pu", port9_pullup_en, 9'h003);
        csr(`IDX_P9_WAKE, 8'h63);
        csr(`IDX_P9_LED, 8'h0C);
        csr(`IDX_P9_PULLUP, 8'hE3);
        csw(`IDX_P9_WAKE, 8'hFF);
        chk("wake", port9_wake_en, 9'h000);
        $display("test ports done");
    endtask
    task t_special;
        csw(`IDX_SPECIAL, 8'h13);
        chk("pu56", {port6_pullup_en, port5_pullup_en}, 9'h000);
        chk("pcw", {port_change_wake_disable, usb_ctrl_run}, 9'h000);
        chk("clk", {normal_clock, watchdog_enable_bit}, 9'h000);
        csw(`IDX_SPECIAL, 8'hA8);
        chk("pu56", {port6_pullup_en, port5_pullup_en}, 9'h003);
        chk("clk", {normal_clock, watchdog_enable_bit}, 9'h003);
        chk("pcw", {port_change_wake_disable, usb_ctrl_run}, 9'h001);
        chk("run", system_clock_run, 9'h000);
        wake_signal <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("run", system_clock_run, 9'h001);
        wake_signal <= 1'b1;
        csw(`IDX_SPECIAL, 8'h18);
        chk("resume", resume_request, 9'h001);
        usb_suspend <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("resume", resume_request, 9'h000);
        usb_suspend <= 1'b1;
        set_feature_wake <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("rwake", remote_wake_supported, 9'h001);
        set_feature_wake <= 1'b0;
        clear_feature_wake <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("rwake", remote_wake_supported, 9'h000);
        clear_feature_wake <= 1'b0;
        $display("test special done");
    endtask
    task t_acc;
        @(posedge ref_clk);
        acc_load <= 1'b1;
        acc_d <= 8'h5A;
        @(posedge ref_clk);
        acc_load <= 1'b0;
        int_taken <= 1'b1;
        @(posedge ref_clk);
        int_taken <= 1'b0;
        acc_load <= 1'b1;
        acc_d <= 8'h11;
        @(posedge ref_clk);
        acc_load <= 1'b0;
        acc_restore <= 1'b1;
        #1;
        chk("acc", acc_value, 9'h011);
        @(posedge ref_clk);
        acc_restore <= 1'b0;
        #1;
        chk("saved", acc_saved, 9'h05A);
        chk("acc", acc_value, 9'h05A);
        $display("test accumulator done");
    endtask

    task wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 0;
        srst = 1;
        {read_prescale_reg_instr, write_prescale_reg_instr} = 0;
        {control_space_read_instr, control_space_write_instr} = 0;
        {disable_interrupts_instr, enable_interrupts_instr} = 0;
        {return_from_interrupt_instr, acc_load, int_taken, acc_restore} = 0;
        {set_feature_wake, clear_feature_wake} = 0;
        {usb_suspend, wake_signal} = 2'b11;
        {ctrl_addr, wr_data, acc_d} = 0;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset;
        t_prescale;
        t_int;
        t_spi;
        t_mode;
        t_ports;
        t_special;
        t_acc;
        wrap_up;
    end
endmodule // special_ctrl_regs_tb

// file: verilog/ctrl_regs_defs.vh
// Register indices, field positions, reset values and timing constants
`ifndef CTRL_REGS_DEFS_VH
`define CTRL_REGS_DEFS_VH

// ------------------------------------------------------------
// Control-space register indices
// ------------------------------------------------------------
`define IDX_PORT5_DIR      4'h5
`define IDX_PORT6_DIR      4'h6
`define IDX_PORT7_DIR      4'h7
`define IDX_SPI_CTRL       4'h8
`define IDX_PORT9_DIR      4'h9
`define IDX_MODE_CTRL      4'hA
`define IDX_P9_WAKE        4'hB
`define IDX_P9_LED         4'hC
`define IDX_P9_PULLUP      4'hD
`define IDX_SPECIAL        4'hE

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_PRESCALE       8'h3F
`define RST_PORT_DIR       8'hFF
`define RST_SPI_CTRL       8'h00
`define RST_MODE_CTRL      8'hE3
`define RST_P9_WAKE        8'h7F
`define RST_P9_LED         8'h00
`define RST_P9_PULLUP      8'hEF
`define RST_SPECIAL        8'hD7

// ------------------------------------------------------------
// Writable bit masks; writes leave other bits at their current value
// ------------------------------------------------------------
`define WM_PRESCALE        8'hBF
`define WM_SPI_CTRL        8'hF7
`define WM_MODE_CTRL       8'hE3
`define WM_P9_WAKE         8'h1C
`define WM_P9_LED          8'h0C
`define WM_P9_PULLUP       8'h0C
`define WM_SPECIAL         8'hFB

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PS_IDIS_BIT        6
`define PS_LED_BIT         7
`define MODE_RWAKE_BIT     4
`define SPEC_RESUME_BIT    3
`define SPEC_RUN_BIT       4
`define SPEC_DUAL_BIT      7

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define WDT_BASE_MS        8

`endif

// file: verilog/special_ctrl_regs.v
// Special control register bank of the microcontroller core
// Functional notes
// - Prescale reg via own instrs; others control-space
// - Eight-bit accumulator, auto-saved on interrupt
// - Low three bits: watchdog prescale 1:1..1:128
// - Bits 3-5: timer prescale 1:2..1:256
// - Disable bit set/cleared by interrupt instructions
// - Top bit enables Port 7 LED sink
// - Direction bit 1 input, reset all ones
// - Edge select swaps SPI edges; bit6 enables
// - SPI bits 5,4 open-drain SDO, SCK
// - Rate bits select master divider or slave
// - Two mode bits select operation mode
// - Remote wake bit follows feature requests
// - Mode bit 5 low enables Port 7 pull-ups in mode 1
// - Top mode bits pick dual clock frequency
// - Port 9 wake bits low allow wake
// - Port 9 LED bits enable sink
// - Port 9 pull-up bits low enable
// - Special bits 0,1 disable Port 5/6 pull-ups
// - Resume request cleared when suspend goes low
// - Run bit clear sleeps; wake edge sets
// - Bit5 watchdog enable; bit7 normal clock
`timescale 1ns/1ps
`include "ctrl_regs_defs.vh"

module special_ctrl_regs #(
    parameter CLK_HZ = 200000000
) (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       srst,
    // Core instruction strobes
    input  wire       read_prescale_reg_instr,
    input  wire       write_prescale_reg_instr,
    input  wire       control_space_read_instr,
    input  wire       control_space_write_instr,
    input  wire       disable_interrupts_instr,
    input  wire       enable_interrupts_instr,
    input  wire       return_from_interrupt_instr,
    input  wire [3:0] ctrl_addr,
    input  wire [7:0] wr_data,
    output reg  [7:0] rd_data,
    // Accumulator
    input  wire       acc_load,
    input  wire [7:0] acc_d,
    output wire [7:0] acc_value,
    input  wire       int_taken,
    input  wire       acc_restore,
    output wire [7:0] acc_saved,
    // Hardware events (from outside the clock domain)
    input  wire       set_feature_wake,
    input  wire       clear_feature_wake,
    input  wire       usb_suspend,
    input  wire       wake_signal,
    // Timer and watchdog controls
    output wire [2:0] watchdog_prescale_sel,
    output wire [2:0] timer_prescale_sel,
    output wire [7:0] watchdog_ratio,
    output wire [8:0] timer_ratio,
    output wire       int_blocked,
    output wire       watchdog_enable_bit,
    // Port controls
    output wire       port7_led_sink,
    output wire [7:0] port5_dir,
    output wire [7:0] port6_dir,
    output wire [7:0] port7_dir,
    output wire [7:0] port9_dir,
    output wire       port7_pullup_en,
    output wire [2:0] port9_wake_en,
    output wire [1:0] port9_led_sink,
    output wire [1:0] port9_pullup_en,
    output wire       port5_pullup_en,
    output wire       port6_pullup_en,
    output wire       port_change_wake_disable,
    // SPI controls
    output wire       spi_enable_bit,
    output wire       spi_edge_select,
    output wire       sck_idle_level,
    output wire       sdo_open_drain,
    output wire       sck_open_drain,
    output wire       spi_master,
    output wire       spi_ss_honored,
    output wire [6:0] spi_divisor,
    // Mode and clock controls
    output wire [1:0] op_mode,
    output wire       remote_wake_supported,
    output wire [1:0] dual_freq_sel,
    output wire       normal_clock,
    output wire       usb_ctrl_run,
    output wire       system_clock_run,
    output wire       resume_request
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg  [3:0] sync1_q;
    reg  [3:0] sync2_q;
    reg        wake_prev_q;
    reg        susp_prev_q;

    always @(posedge ref_clk) begin
        if (srst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            wake_prev_q <= 1'b0;
            susp_prev_q <= 1'b0;
        end else begin
            sync1_q <= {wake_signal, usb_suspend,
                        clear_feature_wake, set_feature_wake};
            sync2_q <= sync1_q;
            wake_prev_q <= sync2_q[3];
            susp_prev_q <= sync2_q[2];
        end
    end

    // Feature requests are levels; edges make them one-shot
    reg  [1:0] feat_prev_q;
    always @(posedge ref_clk) begin
        if (srst)
            feat_prev_q <= 2'h0;
        else
            feat_prev_q <= sync2_q[1:0];
    end

    wire set_wake_ev   = sync2_q[0] & ~feat_prev_q[0];
    wire clr_wake_ev   = sync2_q[1] & ~feat_prev_q[1];
    wire susp_fall     = susp_prev_q & ~sync2_q[2];
    wire wake_fall     = wake_prev_q & ~sync2_q[3];

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    reg  [7:0] acc_q;
    reg  [7:0] acc_save_q;

    always @(posedge ref_clk) begin
        if (srst) begin
            acc_q <= 8'h00;
            acc_save_q <= 8'h00;
        end else begin
            if (int_taken)
                acc_save_q <= acc_q;
            if (acc_restore)
                acc_q <= acc_save_q;
            else if (acc_load)
                acc_q <= acc_d;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0] prescale_interrupt_control_q;
    reg  [7:0] dir_q [0:3];
    reg  [7:0] serial_periph_control_q;
    reg  [7:0] operation_mode_control_q;
    reg  [7:0] port9_wake_select_q;
    reg  [7:0] port9_led_sink_control_q;
    reg  [7:0] port9_pullup_control_q;
    reg  [7:0] special_function_control_q;

    wire cw = control_space_write_instr;

    // Merge writable bits only; reserved bits keep reset value
    function [7:0] merge;
        input [7:0] old_v;
        input [7:0] new_v;
        input [7:0] mask;
        begin
            merge = (old_v & ~mask) | (new_v & mask);
        end
    endfunction

    integer i;
    always @(posedge ref_clk) begin
        if (srst) begin
            for (i = 0; i < 4; i = i + 1)
                dir_q[i] <= `RST_PORT_DIR;
        end else if (cw) begin
            case (ctrl_addr)
                `IDX_PORT5_DIR: dir_q[0] <= wr_data;
                `IDX_PORT6_DIR: dir_q[1] <= wr_data;
                `IDX_PORT7_DIR: dir_q[2] <= wr_data;
                `IDX_PORT9_DIR: dir_q[3] <= wr_data;
                default: ;
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            prescale_interrupt_control_q <= `RST_PRESCALE;
        end else begin
            if (write_prescale_reg_instr)
                prescale_interrupt_control_q <=
                    merge(prescale_interrupt_control_q, wr_data,
                          `WM_PRESCALE);
            // Disable wins when both arrive together
            if (disable_interrupts_instr)
                prescale_interrupt_control_q[`PS_IDIS_BIT] <= 1'b1;
            else if (enable_interrupts_instr |
                     return_from_interrupt_instr)
                prescale_interrupt_control_q[`PS_IDIS_BIT] <= 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            serial_periph_control_q  <= `RST_SPI_CTRL;
            port9_wake_select_q      <= `RST_P9_WAKE;
            port9_led_sink_control_q <= `RST_P9_LED;
            port9_pullup_control_q   <= `RST_P9_PULLUP;
        end else if (cw) begin
            case (ctrl_addr)
                `IDX_SPI_CTRL: serial_periph_control_q <=
                    merge(serial_periph_control_q, wr_data,
                          `WM_SPI_CTRL);
                `IDX_P9_WAKE: port9_wake_select_q <=
                    merge(port9_wake_select_q, wr_data,
                          `WM_P9_WAKE);
                `IDX_P9_LED: port9_led_sink_control_q <=
                    merge(port9_led_sink_control_q, wr_data,
                          `WM_P9_LED);
                `IDX_P9_PULLUP: port9_pullup_control_q <=
                    merge(port9_pullup_control_q, wr_data,
                          `WM_P9_PULLUP);
                default: ;
            endcase
        end
    end

    // Remote wake bit is hardware owned; feature events win
    always @(posedge ref_clk) begin
        if (srst) begin
            operation_mode_control_q <= `RST_MODE_CTRL;
        end else begin
            if (cw && ctrl_addr == `IDX_MODE_CTRL)
                operation_mode_control_q <=
                    merge(operation_mode_control_q, wr_data,
                          `WM_MODE_CTRL);
            if (set_wake_ev)
                operation_mode_control_q[`MODE_RWAKE_BIT] <= 1'b1;
            else if (clr_wake_ev)
                operation_mode_control_q[`MODE_RWAKE_BIT] <= 1'b0;
        end
    end

    // Hardware set/clear takes priority over the same-cycle write
    always @(posedge ref_clk) begin
        if (srst) begin
            special_function_control_q <= `RST_SPECIAL;
        end else begin
            if (cw && ctrl_addr == `IDX_SPECIAL)
                special_function_control_q <=
                    merge(special_function_control_q, wr_data,
                          `WM_SPECIAL);
            if (susp_fall)
                special_function_control_q[`SPEC_RESUME_BIT] <= 1'b0;
            if (wake_fall)
                special_function_control_q[`SPEC_RUN_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always @* begin
        rd_data = 8'h00;
        if (read_prescale_reg_instr)
            rd_data = prescale_interrupt_control_q;
        else if (control_space_read_instr) begin
            case (ctrl_addr)
                `IDX_PORT5_DIR: rd_data = dir_q[0];
                `IDX_PORT6_DIR: rd_data = dir_q[1];
                `IDX_PORT7_DIR: rd_data = dir_q[2];
                `IDX_SPI_CTRL:  rd_data = serial_periph_control_q;
                `IDX_PORT9_DIR: rd_data = dir_q[3];
                `IDX_MODE_CTRL: rd_data = operation_mode_control_q;
                `IDX_P9_WAKE:   rd_data = port9_wake_select_q;
                `IDX_P9_LED:    rd_data = port9_led_sink_control_q;
                `IDX_P9_PULLUP: rd_data = port9_pullup_control_q;
                `IDX_SPECIAL:   rd_data = special_function_control_q;
                default:        rd_data = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    wire [2:0] spi_rate_select = serial_periph_control_q[2:0];

    assign acc_value = acc_q;
    assign acc_saved = acc_save_q;
    assign watchdog_prescale_sel = prescale_interrupt_control_q[2:0];
    assign timer_prescale_sel    = prescale_interrupt_control_q[5:3];
    assign watchdog_ratio = 8'h01 << watchdog_prescale_sel;
    assign timer_ratio    = 9'h002 << timer_prescale_sel;
    assign int_blocked = prescale_interrupt_control_q[`PS_IDIS_BIT];
    assign port7_led_sink =
        prescale_interrupt_control_q[`PS_LED_BIT];
    assign port5_dir = dir_q[0];
    assign port6_dir = dir_q[1];
    assign port7_dir = dir_q[2];
    assign port9_dir = dir_q[3];

    assign spi_edge_select = serial_periph_control_q[7];
    assign sck_idle_level  = serial_periph_control_q[7];
    assign spi_enable_bit  = serial_periph_control_q[6];
    assign sdo_open_drain  = serial_periph_control_q[5];
    assign sck_open_drain  = serial_periph_control_q[4];
    // Slave codes leave the divisor unused
    assign spi_master     = (spi_rate_select < 3'h6);
    assign spi_ss_honored = (spi_rate_select == 3'h6);
    assign spi_divisor = spi_master ?
        (7'h02 << spi_rate_select) : 7'h00;

    assign op_mode = operation_mode_control_q[1:0];
    assign remote_wake_supported =
        operation_mode_control_q[`MODE_RWAKE_BIT];
    // Port 7 pull-ups only apply in USB mode
    assign port7_pullup_en = ~operation_mode_control_q[5] &
                             (op_mode == 2'h1);
    assign dual_freq_sel = operation_mode_control_q[7:6];

    assign port9_wake_en   = ~port9_wake_select_q[4:2];
    assign port9_led_sink  = port9_led_sink_control_q[3:2];
    assign port9_pullup_en = ~port9_pullup_control_q[3:2];

    assign port5_pullup_en = ~special_function_control_q[0];
    assign port6_pullup_en = ~special_function_control_q[1];
    // Resume only honoured in dual clock (slow) mode
    assign resume_request =
        special_function_control_q[`SPEC_RESUME_BIT] &
        ~special_function_control_q[`SPEC_DUAL_BIT];
    assign system_clock_run =
        special_function_control_q[`SPEC_RUN_BIT];
    assign watchdog_enable_bit = special_function_control_q[5];
    assign port_change_wake_disable = special_function_control_q[6];
    assign normal_clock = special_function_control_q[`SPEC_DUAL_BIT];
    assign usb_ctrl_run = normal_clock;

endmodule // special_ctrl_regs
